// >>> inc/scs_consts.vh
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

// register byte offsets
`define SCS_OFF_SYS_MODE_REG 8'h00
`define SCS_OFF_TBC 8'h04
`define SCS_OFF_CFG 8'h08

// sys_mode_reg fields
`define SCS_SYS_MODE_REG_RESET 8'h03
`define SCS_SYS_MODE_REG_CKS_HI 7
`define SCS_SYS_MODE_REG_CKS_LO 5
`define SCS_SYS_MODE_REG_FAST_WAKEUP_ENABLE 4
`define SCS_SYS_MODE_REG_LTO 3
`define SCS_SYS_MODE_REG_HTO 2
`define SCS_SYS_MODE_REG_IDLEN 1
`define SCS_SYS_MODE_REG_HIGH_LOW_CLOCK_SEL 0

// timebase_ctrl_reg fields
`define SCS_TBC_RESET 8'h00
`define SCS_TBC_LXO_LOW_POWER_SEL 0

// configuration option register fields
`define SCS_CFG_RESET 8'h00
`define SCS_CFG_HS_HI 1
`define SCS_CFG_HS_LO 0
`define SCS_CFG_LS 2
`define SCS_CFG_SUB 3
`define SCS_CFG_TBC 4
`define SCS_CFG_WDT 5
`define SCS_CFG_MASK 8'h3f

// high-speed source codes
`define SCS_HS_XTAL 2'h0
`define SCS_HS_ERC 2'h1
`define SCS_HS_HS_INTERNAL_RC_OSC 2'h2

// start-up counts in source clock cycles
`define SCS_XTAL_WAIT 11'h400
`define SCS_LS_INTERNAL_RC_OSC_WAIT 11'h002
`define SCS_HRC_WAIT 11'h010

// divider field: codes below this one select the low clock unless high_low_clock_sel is set
`define SCS_CKS_FIRST_HS 3'h2
`define SCS_WDT_DIV_MAX 2'h3

`endif

// >>> logic/scs_osc_sync.v
`timescale 1ns/1ps
`default_nettype none
// three-stage sampler of an oscillator pin with rising-edge pulse
module scs_osc_sync (
	input wire clk_sys,
	input wire rst,
	input wire osc_in,
	output reg rise
);
	reg s1;
	reg s2;
	reg s3;
	reg lvl;

	always @(posedge clk_sys) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			lvl <= 1'b0;
			rise <= 1'b0;
		end else begin
			s1 <= osc_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				lvl <= s3;
			rise <= (s2 == s3) && s3 && !lvl;
		end
	end
endmodule // scs_osc_sync
`default_nettype wire

// >>> logic/scs_clock_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.vh"
module scs_clock_ctrl (
	input wire clk_sys,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire hxt_in,
	input wire erc_in,
	input wire hs_internal_rc_osc_in,
	input wire lxt_in,
	input wire ls_internal_rc_osc_in,
	input wire halt_req,
	input wire wake_req,
	output reg sys_tick,
	output reg sub_tick,
	output reg timebase_tick,
	output reg wdt_tick,
	output reg hs_osc_enable,
	output reg lxt_enable,
	output reg ls_internal_rc_osc_enable,
	output reg lxo_low_power_sel,
	output reg ls_crystal_pins_gpio,
	output reg cpu_running
);
	localparam [1:0] ST_RUN = 2'h0;
	localparam [1:0] ST_IDLE = 2'h1;
	localparam [1:0] ST_SLEEP = 2'h2;

	// edge mask for the high-speed divider
	function [5:0] div_mask;
		input hl;
		input [2:0] cks;
		begin
			if (hl)
				div_mask = 6'h00;
			else begin
				case (cks)
				3'h2: div_mask = 6'h3f;
				3'h3: div_mask = 6'h1f;
				3'h4: div_mask = 6'h0f;
				3'h5: div_mask = 6'h07;
				3'h6: div_mask = 6'h03;
				3'h7: div_mask = 6'h01;
				default: div_mask = 6'h00;
				endcase
			end
		end
	endfunction

	// start-up counter step: stops at the target
	function [10:0] ready_step;
		input [10:0] cnt;
		input [10:0] target;
		input tick;
		begin
			if (tick && cnt < target)
				ready_step = cnt + 11'h001;
			else
				ready_step = cnt;
		end
	endfunction

	wire hxt_rise;
	wire erc_rise;
	wire hs_internal_rc_osc_rise;
	wire lxt_rise;
	wire ls_internal_rc_osc_rise;

	scs_osc_sync u_hxt (
		.clk_sys(clk_sys),
		.rst(rst),
		.osc_in(hxt_in),
		.rise(hxt_rise)
	);
	scs_osc_sync u_erc (
		.clk_sys(clk_sys),
		.rst(rst),
		.osc_in(erc_in),
		.rise(erc_rise)
	);
	scs_osc_sync u_hs_internal_rc_osc (
		.clk_sys(clk_sys),
		.rst(rst),
		.osc_in(hs_internal_rc_osc_in),
		.rise(hs_internal_rc_osc_rise)
	);
	scs_osc_sync u_lxt (
		.clk_sys(clk_sys),
		.rst(rst),
		.osc_in(lxt_in),
		.rise(lxt_rise)
	);
	scs_osc_sync u_ls_internal_rc_osc (
		.clk_sys(clk_sys),
		.rst(rst),
		.osc_in(ls_internal_rc_osc_in),
		.rise(ls_internal_rc_osc_rise)
	);

	reg [7:0] sys_mode_reg;
	reg [7:0] cfg_option_reg;
	reg [1:0] state;
	reg [10:0] hs_cnt;
	reg [10:0] lxt_cnt;
	reg [10:0] ls_internal_rc_osc_cnt;
	reg [5:0] hs_div_cnt;
	reg [1:0] wdt_div_cnt;
	reg fast_wake;

	wire [2:0] cks = sys_mode_reg[`SCS_SYS_MODE_REG_CKS_HI:`SCS_SYS_MODE_REG_CKS_LO];
	wire high_low_clock_sel = sys_mode_reg[`SCS_SYS_MODE_REG_HIGH_LOW_CLOCK_SEL];
	wire fast_wakeup_enable = sys_mode_reg[`SCS_SYS_MODE_REG_FAST_WAKEUP_ENABLE];
	wire idlen = sys_mode_reg[`SCS_SYS_MODE_REG_IDLEN];
	wire [1:0] hs_src = cfg_option_reg[`SCS_CFG_HS_HI:`SCS_CFG_HS_LO];
	wire ls_src = cfg_option_reg[`SCS_CFG_LS];
	wire sub_src = cfg_option_reg[`SCS_CFG_SUB];
	wire tbc_src = cfg_option_reg[`SCS_CFG_TBC];
	wire wdt_src = cfg_option_reg[`SCS_CFG_WDT];

	// high-speed source and its start-up length
	reg hs_rise;
	always @* begin
		case (hs_src)
		`SCS_HS_XTAL: hs_rise = hxt_rise;
		`SCS_HS_ERC: hs_rise = erc_rise;
		`SCS_HS_HS_INTERNAL_RC_OSC: hs_rise = hs_internal_rc_osc_rise;
		default: hs_rise = hs_internal_rc_osc_rise;
		endcase
	end
	wire [10:0] hs_target = (hs_src == `SCS_HS_XTAL) ?
		`SCS_XTAL_WAIT : `SCS_HRC_WAIT;

	wire hs_ready = (hs_cnt == hs_target);
	wire lxt_ready = (lxt_cnt == `SCS_XTAL_WAIT);
	wire ls_internal_rc_osc_ready = (ls_internal_rc_osc_cnt == `SCS_LS_INTERNAL_RC_OSC_WAIT);
	wire ls_ready = ls_src ? ls_internal_rc_osc_ready : lxt_ready;

	// a crystal edge counts only once the crystal has started
	wire lxt_ok = lxt_rise && lxt_ready;
	wire ls_internal_rc_osc_ok = ls_internal_rc_osc_rise && ls_internal_rc_osc_ready;
	wire ls_edge = ls_src ? ls_internal_rc_osc_ok : lxt_ok;
	wire sub_edge = sub_src ? ls_internal_rc_osc_ok : lxt_ok;
	wire tbc_edge = tbc_src ? ls_internal_rc_osc_ok : lxt_ok;

	wire sel_hs = high_low_clock_sel || (cks >= `SCS_CKS_FIRST_HS);
	wire [5:0] mask = div_mask(high_low_clock_sel, cks);
	wire hs_div_edge = hs_rise && ((hs_div_cnt & mask) == mask);

	reg next_sys;
	always @* begin
		if (sel_hs) begin
			if (hs_ready)
				next_sys = hs_div_edge;
			else if (fast_wake)
				next_sys = sub_edge;
			else
				next_sys = 1'b0;
		end else
			next_sys = ls_edge;
	end

	wire lxt_used = !ls_src || !sub_src || !tbc_src;
	wire asleep = (state == ST_SLEEP);
	wire running = (state == ST_RUN);

	// operating state and wake-up handling
	always @(posedge clk_sys) begin
		if (rst) begin
			state <= ST_RUN;
			fast_wake <= 1'b0;
		end else begin
			case (state)
			ST_RUN: begin
				if (halt_req)
					state <= idlen ? ST_IDLE : ST_SLEEP;
				if (hs_ready)
					fast_wake <= 1'b0;
			end
			ST_IDLE, ST_SLEEP: begin
				if (wake_req) begin
					state <= ST_RUN;
					fast_wake <= fast_wakeup_enable && sel_hs;
				end
			end
			default: state <= ST_RUN;
			endcase
		end
	end

	// start-up counters restart whenever the oscillator is stopped
	always @(posedge clk_sys) begin
		if (rst) begin
			hs_cnt <= 11'h000;
			lxt_cnt <= 11'h000;
			ls_internal_rc_osc_cnt <= 11'h000;
		end else begin
			if (!running || !sel_hs)
				hs_cnt <= 11'h000;
			else
				hs_cnt <= ready_step(hs_cnt, hs_target, hs_rise);
			if (asleep || !lxt_used)
				lxt_cnt <= 11'h000;
			else
				lxt_cnt <= ready_step(lxt_cnt, `SCS_XTAL_WAIT,
					lxt_rise);
			if (asleep)
				ls_internal_rc_osc_cnt <= 11'h000;
			else
				ls_internal_rc_osc_cnt <= ready_step(ls_internal_rc_osc_cnt, `SCS_LS_INTERNAL_RC_OSC_WAIT,
					ls_internal_rc_osc_rise);
		end
	end

	// divider counters
	always @(posedge clk_sys) begin
		if (rst) begin
			hs_div_cnt <= 6'h00;
			wdt_div_cnt <= 2'h0;
		end else begin
			if (!running || !sel_hs)
				hs_div_cnt <= 6'h00;
			else if (hs_rise)
				hs_div_cnt <= hs_div_cnt + 6'h01;
			if (running && next_sys)
				wdt_div_cnt <= wdt_div_cnt + 2'h1;
		end
	end

	// clock tick and oscillator control outputs
	always @(posedge clk_sys) begin
		if (rst) begin
			sys_tick <= 1'b0;
			sub_tick <= 1'b0;
			timebase_tick <= 1'b0;
			wdt_tick <= 1'b0;
			hs_osc_enable <= 1'b0;
			lxt_enable <= 1'b0;
			ls_internal_rc_osc_enable <= 1'b0;
			ls_crystal_pins_gpio <= 1'b0;
			cpu_running <= 1'b0;
		end else begin
			sys_tick <= running && next_sys;
			sub_tick <= !asleep && sub_edge;
			timebase_tick <= !asleep && tbc_edge;
			if (wdt_src)
				wdt_tick <= running && next_sys &&
					(wdt_div_cnt == `SCS_WDT_DIV_MAX);
			else
				wdt_tick <= !asleep && sub_edge;
			hs_osc_enable <= running && sel_hs;
			lxt_enable <= lxt_used && !asleep;
			ls_internal_rc_osc_enable <= !asleep;
			ls_crystal_pins_gpio <= !lxt_used;
			cpu_running <= running;
		end
	end

	// wishbone slave: one-cycle answer, writes land with ack
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
	reg [7:0] rd_byte;
	always @* begin
		case (wb_adr_i)
		`SCS_OFF_SYS_MODE_REG: begin
			rd_byte = sys_mode_reg;
			rd_byte[`SCS_SYS_MODE_REG_LTO] = ls_ready;
			rd_byte[`SCS_SYS_MODE_REG_HTO] = hs_ready;
		end
		`SCS_OFF_TBC: begin
			rd_byte = `SCS_TBC_RESET;
			rd_byte[`SCS_TBC_LXO_LOW_POWER_SEL] = lxo_low_power_sel;
		end
		`SCS_OFF_CFG: rd_byte = cfg_option_reg;
		default: rd_byte = 8'h00;
		endcase
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			sys_mode_reg <= `SCS_SYS_MODE_REG_RESET;
			cfg_option_reg <= `SCS_CFG_RESET;
			lxo_low_power_sel <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req)
				wb_dat_o <= {24'h000000, rd_byte};
			if (wb_wr) begin
				case (wb_adr_i)
				`SCS_OFF_SYS_MODE_REG: begin
					sys_mode_reg <= wb_dat_i[7:0];
					sys_mode_reg[`SCS_SYS_MODE_REG_LTO] <= 1'b0;
					sys_mode_reg[`SCS_SYS_MODE_REG_HTO] <= 1'b0;
				end
				`SCS_OFF_TBC:
					// software raises this once the crystal settled
					lxo_low_power_sel <=
						wb_dat_i[`SCS_TBC_LXO_LOW_POWER_SEL];
				`SCS_OFF_CFG:
					cfg_option_reg <= wb_dat_i[7:0] & `SCS_CFG_MASK;
				default: ;
				endcase
			end
		end
	end
endmodule // scs_clock_ctrl
`default_nettype wire

// >>> verif/scs_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model (
	input wire logic clk_sys,
	input wire logic hs_en,
	input wire logic lxt_en,
	input wire logic ls_internal_rc_osc_en,
	output logic [4:0] pin
);
	logic [7:0] c = 8'h00;
	always @(posedge clk_sys) begin
		c <= c + 8'h01;
		// stopped sources stand low; crystal runs in either power mode
		pin <= {ls_internal_rc_osc_en & c[2], lxt_en & c[2], {3{hs_en & c[1]}}};
	end
endmodule // scs_osc_model
`default_nettype wire

// >>> verif/scs_clock_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module scs_clock_ctrl_chk (
	input wire clk_sys,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire sys_tick,
	input wire timebase_tick,
	input wire hs_osc_enable,
	input wire lxt_enable,
	input wire lxo_low_power_sel,
	input wire ls_crystal_pins_gpio,
	input wire cpu_running
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_ack_next: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("long ack");
	a_ack_hi_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("high bytes set");
	a_lp_reset: assert property (disable iff (1'b0)
		rst |=> !lxo_low_power_sel) else $error("low power after reset");
	a_lp_by_write: assert property ($changed(lxo_low_power_sel)
		|-> wb_ack_o || $past(wb_ack_o)) else $error("low power moved");
	a_gpio_no_lxt: assert property (
		ls_crystal_pins_gpio && $past(ls_crystal_pins_gpio) |-> !lxt_enable)
		else $error("crystal on pins");
	a_halt_no_sys: assert property (!cpu_running [*3] |-> !sys_tick)
		else $error("tick while halted");
	a_halt_no_hs: assert property (!cpu_running [*2] |-> !hs_osc_enable)
		else $error("fast osc while halted");
	a_tb_pulse: assert property (timebase_tick |=> !timebase_tick)
		else $error("long timebase tick");
	c_halt: cover property (!cpu_running ##1 cpu_running);
	c_gpio: cover property (ls_crystal_pins_gpio);
	c_tick: cover property (sys_tick && timebase_tick);
endmodule // scs_clock_ctrl_chk
bind scs_clock_ctrl scs_clock_ctrl_chk scs_clock_ctrl_chk_i (.*);
`default_nettype wire

// >>> verif/test_scs_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
	$display("ERROR %0t got %0h want %0h", $time, a, e); end end
module test_scs_clock_ctrl;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00, rd, v, t;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic halt_req = 1'h0, wake_req = 1'h0, sys_tick, sub_tick, timebase_tick;
	logic wdt_tick, hs_osc_enable, lxt_enable, ls_internal_rc_osc_enable, lxo_low_power_sel;
	logic ls_crystal_pins_gpio, cpu_running;
	logic [4:0] pin;
	logic [3:0] tk;
	int bad_count = 0, n_compared = 0, seed = 32'hfafd, ns, nw, nt, nu, k;
	scs_clock_ctrl scs_clock_ctrl_i (.*, .hxt_in(pin[0]), .erc_in(pin[1]),
		.hs_internal_rc_osc_in(pin[2]), .lxt_in(pin[3]), .ls_internal_rc_osc_in(pin[4]));
	scs_osc_model scs_osc_model_i (.clk_sys(clk_sys), .hs_en(hs_osc_enable),
		.lxt_en(lxt_enable), .ls_internal_rc_osc_en(ls_internal_rc_osc_enable), .pin(pin));
	initial forever #5 clk_sys = ~clk_sys;
	function automatic bit near(int a, int e);
		return a >= e - 1 && a <= e + 1;
	endfunction
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <=
			{2'h3, we, 4'h1, a, 24'h0, d};
		k = 0;
		do begin @(posedge clk_sys); k++; end while (wb_ack_o !== 1'h1 && k < 20);
		if (k >= 20) begin bad_count++; close_out(); end
		rd = wb_dat_o[7:0];
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge clk_sys);
	endtask
	task automatic pulse(input logic w);
		if (w) wake_req <= 1'h1; else halt_req <= 1'h1;
		@(posedge clk_sys);
		{halt_req, wake_req} <= 2'h0;
		// let the ticks of the last running cycle drain before counting
		@(posedge clk_sys);
	endtask
	task automatic cnt(input int w);
		{ns, nw, nt, nu} = 0;
		repeat (w) begin
			@(posedge clk_sys);
			tk = {sys_tick, sub_tick, wdt_tick, timebase_tick};
			`CHK($isunknown(tk), 1'h0)
			ns += sys_tick;
			nw += wdt_tick;
			nt += timebase_tick;
			nu += sub_tick;
		end
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'h0;
		bus(1'h0, 8'h04, 8'h00);
		`CHK(rd, 8'h00)
		bus(1'h0, 8'h0c, 8'h00);
		`CHK(rd, 8'h00)
		cnt(3500);
		`CHK(ns, 0)
		bus(1'h0, 8'h00, 8'h00);
		`CHK(rd, 8'h03)
		cnt(800);
		bus(1'h0, 8'h00, 8'h00);
		`CHK(rd[2], 1'h1)
		cnt(1024);
		`CHK(near(ns, 256), 1'h1)
		cnt(4000);
		bus(1'h0, 8'h00, 8'h00);
		`CHK(rd[3], 1'h1)
		$display("start-up done");
		bus(1'h1, 8'h08, 8'h20);
		for (int c = 7; c >= 0; c--) begin
			bus(1'h1, 8'h00, {c[2:0], 5'h00});
			cnt(300);
			cnt(1024);
			`CHK(near(ns, c < 2 ? 128 : 256 >> (8 - c)), 1'h1)
			`CHK(near(nw, ns / 4), 1'h1)
			`CHK(near(nt, 128), 1'h1)
			`CHK(hs_osc_enable, c > 1)
		end
		$display("divider done");
		for (int i = 0; i < 6; i++) begin
			v = i == 5 ? 8'h1c : 8'($random(seed));
			t = 8'($random(seed));
			bus(1'h1, 8'h04, t);
			bus(1'h1, 8'h08, v);
			bus(1'h0, 8'h08, 8'h00);
			`CHK(rd, v & 8'h3f)
			`CHK(lxo_low_power_sel, t[0])
			`CHK(ls_crystal_pins_gpio, v[4:2] == 3'h7)
			`CHK(lxt_enable, v[4:2] != 3'h7)
		end
		bus(1'h1, 8'h00, 8'h00);
		pulse(1'h0);
		cnt(200);
		`CHK(cpu_running, 1'h0)
		`CHK(ns + nt, 0)
		`CHK(nu, 0)
		`CHK(ls_internal_rc_osc_enable, 1'h0)
		pulse(1'h1);
		cnt(20);
		`CHK(cpu_running, 1'h1)
		bus(1'h1, 8'h00, 8'h13);
		pulse(1'h0);
		cnt(200);
		`CHK(ns == 0 && nt > 20, 1'h1)
		`CHK(near(nu, 25), 1'h1)
		`CHK(ls_internal_rc_osc_enable, 1'h1)
		pulse(1'h1);
		cnt(60);
		`CHK(ns > 0, 1'h1)
		bus(1'h0, 8'h00, 8'h00);
		`CHK(rd, 8'h1b)
		bus(1'h1, 8'h00, 8'h00);
		bus(1'h1, 8'h08, 8'h1d);
		bus(1'h1, 8'h00, 8'h01);
		cnt(120);
		bus(1'h0, 8'h00, 8'h00);
		`CHK(rd[2], 1'h1)
		$display("modes done");
		close_out();
	end
endmodule // test_scs_clock_ctrl
`default_nettype wire
